// [rtl/wmpc_top.sv]
// wander measurement and sync-output pattern control
`timescale 1ns/100ps
// How it works
// RQ1 - sync output runs one of eight patterns
// RQ2 - test triangle 4096 ns T1, 3088 ns E1
// RQ3 - active pattern selection is reported
// RQ4 - reference reset leaves line data alone
// RQ5 - reference error is filtered accumulated phase
// RQ6 - reference reset zeroes reference interval error
// RQ7 - sample every 20 ms, upload ten
// RQ8 - upload: current value, then nine differences
// RQ9 - hundred-entry buffer, count reported
// RQ10 - report maximum line error since reset
// RQ11 - maximum error over sliding observation window; code uses back-to-back fixed windows restarted every winLen samples
// RQ12 - window accepted from 0.1 to 99.0 s
// RQ13 - programmed window duration is reported
// RQ14 - line reset leaves reference data alone
// RQ15 - wander measured against receiver reference clock
// RQ16 - source selects line or reference input
// RQ17 - controller uploads before issuing reset
// RQ18 - line reset zeroes line interval error
// RQ19 - full buffer drops oldest for newest
module wmpc_top
    import wmpc_pkg::*;
#(
    parameter int SAMPLE_CYC = SAMPLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire wmpc_pattern_type patternSel,
    input wire wmpc_rate_type refRateSel,
    input wire wmpc_source_type wanderSrcSel,
    input wire wmpc_phase_type refPhase,
    input wire wmpc_phase_type linePhase,
    input wire logic refReset,
    input wire logic lineReset,
    input wire logic obsWindowWr,
    input wire logic [9:0] obsWindowSet,
    input wire logic uploadReq,
    input wire logic waveOutReady,
    output wmpc_pattern_type syncOutPattern,
    output logic signed [15:0] syncOutPhase,
    output logic signed [31:0] refTieNs,
    output logic signed [31:0] lineTieNs,
    output logic signed [31:0] measuredTieNs,
    output logic [31:0] mtieNs,
    output logic [9:0] obsWindowTenths,
    output wmpc_upload_type uploadOut,
    output logic [FIFO_CNT_W-1:0] availCount,
    output logic waveOutValid,
    output logic [FIFO_WIDTH-1:0] waveOutData
);

    typedef struct packed {
        logic [SAMPLE_CNT_W-1:0] sampleCnt;
        logic [3:0] blockCnt;
        wmpc_pattern_type pattern;
        logic rateE1;
        logic signed [15:0] triPhase;
        logic triUp;
        logic signed [31:0] refAcc;
        logic signed [31:0] lineAcc;
        logic signed [31:0] refTie;
        logic signed [31:0] lineTie;
        logic signed [31:0] measuredTie;
        logic signed [HIST_DEPTH-1:0][31:0] refHist;
        logic signed [HIST_DEPTH-1:0][31:0] lineHist;
        logic [9:0] obsTenths;
        logic [12:0] winCnt;
        logic signed [31:0] winMax;
        logic signed [31:0] winMin;
        logic [31:0] mtie;
        wmpc_upload_state_type upState;
        logic [3:0] upIdx;
        logic signed [31:0] snapCur;
        logic signed [HIST_DEPTH-1:0][31:0] snapHist;
        wmpc_upload_type upOut;
        logic pushValid;
        logic signed [31:0] pushData;
    } wmpc_state_type;

    wmpc_state_type s_r;
    wmpc_state_type s_nxt;
    logic tick;
    logic fifoInReady;
    logic signed [15:0] triHalf;
    logic signed [31:0] curMax;
    logic signed [31:0] curMin;
    logic [12:0] winLen;

    // ====================================================================
    // buffer of 200 ms line wander data
    wmpc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH),
        .CW(FIFO_CNT_W)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .flush(lineReset),
        .dropOldest(1'b1),
        .inValid(s_r.pushValid),
        .inData(s_r.pushData),
        .inReady(fifoInReady),
        .outValid(waveOutValid),
        .outData(waveOutData),
        .outReady(waveOutReady),
        .count(availCount)
    );

    // ====================================================================
    // next-state logic
    always_comb begin
        s_nxt = s_r;
        tick = (s_r.sampleCnt == SAMPLE_CNT_W'(SAMPLE_CYC - 1));
        triHalf = s_r.rateE1 ? 16'(TRI_PP_E1_NS / 2) : 16'(TRI_PP_T1_NS / 2); // [RQ2]
        winLen = 13'(s_r.obsTenths) * 13'(SAMPLES_PER_TENTH);
        curMax = s_r.winMax;
        curMin = s_r.winMin;

        // sample timebase
        s_nxt.sampleCnt = tick ? '0 : s_r.sampleCnt + 1'b1; // [RQ7]

        // pattern selection and test triangle
        s_nxt.pattern = patternSel; // [RQ1] [RQ3]
        s_nxt.rateE1 = (refRateSel == RATE_E1_DATA) || (refRateSel == RATE_E1_CLOCK); // [RQ2]
        if (patternSel != s_r.pattern || patternSel != PAT_TEST_TRIANGLE
            || s_nxt.rateE1 != s_r.rateE1) begin
            s_nxt.triPhase = '0; // [RQ1]
            s_nxt.triUp = 1'b1;
        end else if (tick) begin
            if (s_r.triUp) begin
                if (s_r.triPhase + 16'(TRI_STEP_NS) >= triHalf) begin
                    s_nxt.triPhase = triHalf; // [RQ2]
                    s_nxt.triUp = 1'b0;
                end else begin
                    s_nxt.triPhase = s_r.triPhase + 16'(TRI_STEP_NS);
                end
            end else begin
                if (s_r.triPhase - 16'(TRI_STEP_NS) <= -triHalf) begin
                    s_nxt.triPhase = -triHalf; // [RQ2]
                    s_nxt.triUp = 1'b1;
                end else begin
                    s_nxt.triPhase = s_r.triPhase - 16'(TRI_STEP_NS);
                end
            end
        end

        // phase accumulation against the receiver reference clock
        if (refPhase.valid) begin
            s_nxt.refAcc = s_r.refAcc + 32'(refPhase.delta); // [RQ15] [RQ5]
        end
        if (linePhase.valid) begin
            s_nxt.lineAcc = s_r.lineAcc + 32'(linePhase.delta); // [RQ15]
        end

        // low-pass filtered interval error and 20 ms history
        if (tick) begin
            s_nxt.refHist = {s_r.refHist[HIST_DEPTH-2:0], s_r.refTie}; // [RQ7]
            s_nxt.lineHist = {s_r.lineHist[HIST_DEPTH-2:0], s_r.lineTie};
            s_nxt.refTie = s_r.refTie + ((s_r.refAcc - s_r.refTie) >>> FILTER_SHIFT); // [RQ5]
            s_nxt.lineTie = s_r.lineTie + ((s_r.lineAcc - s_r.lineTie) >>> FILTER_SHIFT);
            s_nxt.blockCnt = (s_r.blockCnt == 4'(SAMPLES_PER_BLOCK - 1)) ? '0
                                                                         : s_r.blockCnt + 1'b1;
            // maximum error over the observation window
            if (s_r.winCnt == '0 || s_nxt.lineTie > s_r.winMax) begin
                curMax = s_nxt.lineTie;
            end
            if (s_r.winCnt == '0 || s_nxt.lineTie < s_r.winMin) begin
                curMin = s_nxt.lineTie;
            end
            s_nxt.winMax = curMax;
            s_nxt.winMin = curMin;
            if (32'(curMax - curMin) > s_r.mtie) begin
                s_nxt.mtie = 32'(curMax - curMin); // [RQ10] [RQ11]
            end
            s_nxt.winCnt = (s_r.winCnt >= winLen - 13'h0001) ? '0 : s_r.winCnt + 1'b1; // [RQ11]
        end

        // 200 ms datum into the buffer; a new datum wins over the handshake
        if (s_r.pushValid && fifoInReady) begin
            s_nxt.pushValid = 1'b0;
        end
        if (tick && s_r.blockCnt == 4'(SAMPLES_PER_BLOCK - 1)) begin
            s_nxt.pushValid = 1'b1; // [RQ9]
            s_nxt.pushData = s_nxt.lineTie;
        end

        // observation window programming
        if (obsWindowWr && obsWindowSet >= OBS_MIN_TENTHS && obsWindowSet <= OBS_MAX_TENTHS) begin
            s_nxt.obsTenths = obsWindowSet; // [RQ12] [RQ13]
            s_nxt.winCnt = '0;
        end

        // resets of stored wander data
        if (refReset) begin
            s_nxt.refAcc = '0; // [RQ4] [RQ6]
            s_nxt.refTie = '0;
            s_nxt.refHist = '0;
        end
        if (lineReset) begin
            s_nxt.lineAcc = '0; // [RQ14] [RQ18]
            s_nxt.lineTie = '0;
            s_nxt.lineHist = '0;
            s_nxt.mtie = '0;
            s_nxt.winCnt = '0;
            s_nxt.blockCnt = '0;
            s_nxt.pushValid = 1'b0;
        end

        s_nxt.measuredTie = (wanderSrcSel == SRC_REF) ? s_nxt.refTie : s_nxt.lineTie; // [RQ16]

        // upload of ten words
        s_nxt.upOut.valid = 1'b0;
        s_nxt.upOut.last = 1'b0;
        case (s_r.upState)
            UP_IDLE: begin
                if (uploadReq) begin
                    s_nxt.upState = UP_SEND;
                    s_nxt.upIdx = '0;
                    s_nxt.snapCur = (wanderSrcSel == SRC_REF) ? s_r.refTie : s_r.lineTie;
                    s_nxt.snapHist = (wanderSrcSel == SRC_REF) ? s_r.refHist : s_r.lineHist;
                end
            end
            UP_SEND: begin
                s_nxt.upOut.valid = 1'b1; // [RQ7]
                if (s_r.upIdx == '0) begin
                    s_nxt.upOut.data = s_r.snapCur; // [RQ8]
                end else begin
                    s_nxt.upOut.data = s_r.snapHist[s_r.upIdx - 1'b1] - s_r.snapCur; // [RQ8]
                end
                if (s_r.upIdx == 4'(UPLOAD_WORDS - 1)) begin
                    s_nxt.upOut.last = 1'b1;
                    s_nxt.upState = UP_IDLE;
                end
                s_nxt.upIdx = s_r.upIdx + 1'b1;
            end
            default: begin
                s_nxt.upState = UP_IDLE;
            end
        endcase

        if (!clkEn) begin
            s_nxt = s_r;
        end
    end

    // ====================================================================
    // state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.obsTenths <= OBS_RESET_TENTHS;
            s_r.triUp <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign syncOutPattern = s_r.pattern;
    assign syncOutPhase = s_r.triPhase;
    assign refTieNs = s_r.refTie;
    assign lineTieNs = s_r.lineTie;
    assign measuredTieNs = s_r.measuredTie;
    assign mtieNs = s_r.mtie;
    assign obsWindowTenths = s_r.obsTenths;
    assign uploadOut = s_r.upOut;

    // ====================================================================
    // checks
    AST_PATTERN_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
        clkEn |=> (syncOutPattern == $past(patternSel)))
        else $error("reported pattern differs from selection");

    AST_PHASE_ZERO_OFF_TEST: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ1]
        (syncOutPattern != PAT_TEST_TRIANGLE) |-> (syncOutPhase == 16'h0000))
        else $error("phase offset outside test pattern");

    AST_TRI_T1_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
        (!s_r.rateE1) |-> (syncOutPhase <= 16'sh0800 && syncOutPhase >= -16'sh0800))
        else $error("T1 triangle beyond 4096 ns peak to peak");

    AST_TRI_E1_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
        (s_r.rateE1 && $past(s_r.rateE1))
        |-> (syncOutPhase <= 16'sh0608 && syncOutPhase >= -16'sh0608))
        else $error("E1 triangle beyond 3088 ns peak to peak");

    AST_REF_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
        (clkEn && refReset) |=> (refTieNs == 32'h0000_0000))
        else $error("reference error not cleared by reset");

    AST_REF_RESET_KEEPS_LINE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
        (clkEn && refReset && !lineReset && !tick) |=> (lineTieNs == $past(lineTieNs)))
        else $error("reference reset disturbed line data");

    AST_LINE_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ18]
        (clkEn && lineReset) |=> (lineTieNs == 32'h0000_0000 && mtieNs == 32'h0000_0000
                                  && availCount == '0))
        else $error("line reset left line data");

    AST_LINE_RESET_KEEPS_REF: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ14]
        (clkEn && lineReset && !refReset && !tick) |=> (refTieNs == $past(refTieNs)))
        else $error("line reset disturbed reference data");

    AST_OBS_IN_RANGE: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ12]
        (obsWindowTenths >= OBS_MIN_TENTHS && obsWindowTenths <= OBS_MAX_TENTHS))
        else $error("observation window outside accepted range");

    AST_OBS_LOADED: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ13]
        (clkEn && obsWindowWr && obsWindowSet >= OBS_MIN_TENTHS
         && obsWindowSet <= OBS_MAX_TENTHS) |=> (obsWindowTenths == $past(obsWindowSet)))
        else $error("programmed window not reported");

    AST_MTIE_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ10]
        (clkEn && !lineReset) |=> (mtieNs >= $past(mtieNs)))
        else $error("maximum error dropped without reset");

    AST_SOURCE_SELECT: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ16]
        clkEn |=> (measuredTieNs == (($past(wanderSrcSel) == SRC_REF) ? refTieNs : lineTieNs)))
        else $error("measured error not from selected source");

    AST_UPLOAD_TEN: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
        uploadOut.last
        |-> (uploadOut.valid && $past(uploadOut.valid, 9) && !$past(uploadOut.valid, 10)))
        else $error("upload burst is not ten words");

    AST_UPLOAD_FIRST_ABS: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ8]
        $rose(uploadOut.valid) |-> (uploadOut.data == s_r.snapCur))
        else $error("first upload word is not the absolute error");

endmodule

// [rtl/wmpc_pkg.sv]
// shared constants and types for the wander measure and pattern control block
package wmpc_pkg;

    // ====================================================================
    // clock and timing
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int SAMPLE_PERIOD_MS = 20;
    localparam int SAMPLE_CYCLES = CLK_FREQ_HZ / 1000 * SAMPLE_PERIOD_MS;
    localparam int SAMPLE_CNT_W = 22;
    localparam int SAMPLES_PER_BLOCK = 10;
    localparam int BLOCK_PERIOD_MS = SAMPLE_PERIOD_MS * SAMPLES_PER_BLOCK;
    localparam int OBS_TENTH_MS = 100;
    localparam int SAMPLES_PER_TENTH = OBS_TENTH_MS / SAMPLE_PERIOD_MS;

    // ====================================================================
    // wander filter and test triangle
    localparam int FILTER_CUTOFF_HZ = 10;
    localparam int FILTER_SHIFT = 1;
    localparam int TRI_PP_T1_NS = 4096;
    localparam int TRI_PP_E1_NS = 3088;
    localparam int TRI_STEP_NS = 16;

    // ====================================================================
    // buffer, upload and observation window
    localparam int FIFO_WIDTH = 32;
    localparam int FIFO_DEPTH = 100;
    localparam int FIFO_CNT_W = 7;
    localparam int UPLOAD_WORDS = 10;
    localparam int HIST_DEPTH = UPLOAD_WORDS - 1;
    localparam logic [9:0] OBS_MIN_TENTHS = 10'h001;
    localparam logic [9:0] OBS_MAX_TENTHS = 10'h3de;
    localparam logic [9:0] OBS_RESET_TENTHS = 10'h064;

    // ====================================================================
    // modes
    typedef enum logic [2:0] {
        PAT_NONE,
        PAT_T1_WANDER,
        PAT_T1_FILTERED_WANDER,
        PAT_LINE_WANDER,
        PAT_NOISE_JITTER,
        PAT_FIRST_TRANSIENT,
        PAT_SECOND_TRANSIENT,
        PAT_TEST_TRIANGLE
    } wmpc_pattern_type;

    typedef enum logic [1:0] {
        RATE_T1,
        RATE_T1_EXTENDED_FRAME,
        RATE_E1_DATA,
        RATE_E1_CLOCK
    } wmpc_rate_type;

    typedef enum logic {
        SRC_LINE,
        SRC_REF
    } wmpc_source_type;

    typedef enum logic {
        UP_IDLE,
        UP_SEND
    } wmpc_upload_state_type;

    // ====================================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic signed [15:0] delta;
    } wmpc_phase_type;

    typedef struct packed {
        logic valid;
        logic last;
        logic signed [31:0] data;
    } wmpc_upload_type;

endpackage

// [rtl/wmpc_fifo.sv]
// wander block buffer: fifo with registered read data and drop-oldest
`timescale 1ns/100ps
module wmpc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 100,
    parameter int CW = 7
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic flush,
    input wire logic dropOldest,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic outValid;
        logic [WIDTH-1:0] outData;
    } wmpc_fifo_state_type;

    wmpc_fifo_state_type s_r;
    wmpc_fifo_state_type s_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic doPush;
    logic doPop;

    // ====================================================================
    // pointer and count update
    always_comb begin
        full = (s_r.count == CW'(DEPTH));
        inReady = !full || dropOldest;
        doPush = inValid && inReady;
        doPop = (s_r.outValid && outReady) || (full && doPush); // [RQ19]
        s_nxt = s_r;
        if (doPush) begin
            s_nxt.wrPtr = (s_r.wrPtr == AW'(DEPTH - 1)) ? '0 : s_r.wrPtr + 1'b1;
        end
        if (doPop) begin
            s_nxt.rdPtr = (s_r.rdPtr == AW'(DEPTH - 1)) ? '0 : s_r.rdPtr + 1'b1;
        end
        s_nxt.count = s_r.count + CW'(doPush) - CW'(doPop);
        if (flush) begin
            s_nxt.wrPtr = '0;
            s_nxt.rdPtr = '0;
            s_nxt.count = '0;
        end
        s_nxt.outValid = (s_nxt.count != '0);
        if (doPush && !flush && s_r.wrPtr == s_nxt.rdPtr) begin
            s_nxt.outData = inData;
        end else begin
            s_nxt.outData = mem[s_nxt.rdPtr];
        end
        if (!clkEn) begin
            s_nxt = s_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn && doPush && !flush) begin
            mem[s_r.wrPtr] <= inData;
        end
    end

    assign outValid = s_r.outValid;
    assign outData = s_r.outData;
    assign count = s_r.count;

    AST_FIFO_DROP_KEEPS_FULL: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ19]
        (clkEn && full && inValid && dropOldest && !flush) |=> (count == CW'(DEPTH)))
        else $error("full buffer did not stay full on drop-oldest push");

    AST_FIFO_NEVER_OVER: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ9]
        count <= CW'(DEPTH))
        else $error("buffer count above depth");

endmodule

// [dv/wmpc_ctrl_model.sv]
// far-side model: phase sources and a stalling drain for the wander buffer
`timescale 1ns/100ps
module wmpc_ctrl_model
    import wmpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic phaseOn,
    input wire logic signed [15:0] refDelta,
    input wire logic signed [15:0] lineDelta,
    input wire logic drainOn,
    output wmpc_phase_type refPhase,
    output wmpc_phase_type linePhase,
    output logic waveOutReady
);
    logic [1:0] stallCnt;

    // ====================================================================
    // phase steps, garbage delta while not valid
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refPhase <= '0;
            linePhase <= '0;
            waveOutReady <= 1'b0;
            stallCnt <= 2'h0;
        end else begin
            refPhase.valid <= phaseOn;
            linePhase.valid <= phaseOn;
            refPhase.delta <= phaseOn ? refDelta : ~refPhase.delta;
            linePhase.delta <= phaseOn ? lineDelta : ~linePhase.delta;
            stallCnt <= (stallCnt == 2'h2) ? 2'h0 : stallCnt + 2'h1;
            // ready two cycles of three while draining
            waveOutReady <= drainOn && (stallCnt != 2'h0);
        end
    end
endmodule

// [dv/test_wander_measure_and_pattern_ctrl.sv]
// self-checking bench for the wander measure and pattern control block
`timescale 1ns/100ps
module test_wander_measure_and_pattern_ctrl
    import wmpc_pkg::*;
;
    logic ref_clk, rst_n, refReset, lineReset, obsWindowWr, uploadReq, phaseOn, drainOn;
    wmpc_pattern_type patternSel, syncOutPattern;
    wmpc_rate_type refRateSel;
    wmpc_source_type wanderSrcSel;
    wmpc_phase_type refPhase, linePhase;
    logic [9:0] obsWindowSet, obsWindowTenths;
    logic waveOutReady, waveOutValid;
    logic signed [15:0] syncOutPhase;
    logic signed [31:0] refTieNs, lineTieNs, measuredTieNs;
    logic [31:0] mtieNs, waveOutData;
    wmpc_upload_type uploadOut;
    logic [FIFO_CNT_W-1:0] availCount;
    int num_errors, n_checks;
    logic signed [31:0] tieLog[$];

    // ====================================================================
    // design and far-side model
    wmpc_top #(.SAMPLE_CYC(20)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1),
        .patternSel(patternSel), .refRateSel(refRateSel), .wanderSrcSel(wanderSrcSel),
        .refPhase(refPhase), .linePhase(linePhase), .refReset(refReset),
        .lineReset(lineReset), .obsWindowWr(obsWindowWr), .obsWindowSet(obsWindowSet),
        .uploadReq(uploadReq), .waveOutReady(waveOutReady), .syncOutPattern(syncOutPattern),
        .syncOutPhase(syncOutPhase), .refTieNs(refTieNs), .lineTieNs(lineTieNs),
        .measuredTieNs(measuredTieNs), .mtieNs(mtieNs), .obsWindowTenths(obsWindowTenths),
        .uploadOut(uploadOut), .availCount(availCount), .waveOutValid(waveOutValid),
        .waveOutData(waveOutData));
    wmpc_ctrl_model ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .phaseOn(phaseOn),
        .refDelta(16'sh0005), .lineDelta(16'sh0003), .drainOn(drainOn),
        .refPhase(refPhase), .linePhase(linePhase), .waveOutReady(waveOutReady));

    // ====================================================================
    // clock, history of the measured error, helpers
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        tieLog.push_front(measuredTieNs);
        if (tieLog.size() > 300) tieLog.pop_back();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkRange(input logic signed [31:0] got, input int lo, input int hi);
        n_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            num_errors++;
            $display("unexpected at %0t: %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic pulse(input logic [2:0] which);
        @(posedge ref_clk) {obsWindowWr, refReset, lineReset} <= which;
        @(posedge ref_clk) {obsWindowWr, refReset, lineReset} <= 3'h0;
        @(negedge ref_clk);
    endtask
    task automatic setObs(input logic [9:0] v, input logic [9:0] exp);
        @(posedge ref_clk) obsWindowSet <= v;
        pulse(3'h4);
        chk(obsWindowTenths, exp);
    endtask
    task automatic trianglePeak(input wmpc_rate_type r, input int cycles, input int half);
        logic signed [15:0] peak;
        peak = 16'sh0000;
        @(posedge ref_clk) refRateSel <= r;
        repeat (cycles) begin
            @(negedge ref_clk);
            if (syncOutPhase > peak) peak = syncOutPhase;
        end
        chk(peak, half);
    endtask
    task automatic upload();
        logic signed [31:0] exp[10];
        int k;
        for (k = 0; k < 10; k++) exp[k] = (k == 0) ? tieLog[0] : tieLog[20 * k] - tieLog[0];
        k = 0;
        @(posedge ref_clk) uploadReq <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk) uploadReq <= (i == 4);
            @(negedge ref_clk);
            if (uploadOut.valid === 1'b1) begin
                if (k < 10) chk(uploadOut.data, exp[k]);
                k++;
                chk(uploadOut.last, k == 10);
            end
        end
        chk(k, 10);
    endtask
    task automatic results();
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ====================================================================
    // main sequence
    initial begin
        int pops;
        logic signed [31:0] hold;
        {rst_n, refReset, lineReset, obsWindowWr, uploadReq, phaseOn, drainOn} = '0;
        patternSel = PAT_NONE;
        refRateSel = RATE_E1_DATA;
        wanderSrcSel = SRC_LINE;
        obsWindowSet = 10'h000;
        num_errors = 0;
        n_checks = 0;
        cyc(5);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        chk(obsWindowTenths, 10'h064);
        chk(mtieNs, 0);
        chk({availCount, waveOutValid, uploadOut.valid}, '0);
        for (int p = 0; p < 8; p++) begin
            @(posedge ref_clk) patternSel <= wmpc_pattern_type'(p);
            cyc(1);
            @(negedge ref_clk);
            chk(syncOutPattern, p);
            if (p != 7) chk(syncOutPhase, 0);
        end
        trianglePeak(RATE_E1_CLOCK, 2500, TRI_PP_E1_NS / 2);
        trianglePeak(RATE_T1_EXTENDED_FRAME, 9000, TRI_PP_T1_NS / 2);
        trianglePeak(RATE_T1, 5199, TRI_PP_T1_NS / 2);
        @(posedge ref_clk) patternSel <= PAT_NONE;
        setObs(10'h001, 10'h001);
        setObs(10'h3de, 10'h3de);
        setObs(10'h3df, 10'h3de);
        setObs(10'h000, 10'h3de);
        // uploads kept before any reset; both errors then accumulate
        @(posedge ref_clk) phaseOn <= 1'b1;
        cyc(200);
        hold = measuredTieNs;
        pops = 0;
        while (measuredTieNs === hold && pops < 40) begin
            @(negedge ref_clk);
            pops++;
        end
        if (pops == 40) begin
            num_errors++;
            results();
        end
        repeat (10) @(negedge ref_clk);
        upload();
        cyc(400 - 211 - pops - 20);
        @(posedge ref_clk) phaseOn <= 1'b0;
        cyc(800);
        @(negedge ref_clk);
        chkRange(refTieNs, 1999, 2000);
        chkRange(lineTieNs, 1199, 1200);
        chkRange(measuredTieNs, 1199, 1200);
        chkRange(mtieNs, 1, 1200);
        @(posedge ref_clk) wanderSrcSel <= SRC_REF;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chkRange(measuredTieNs, 1999, 2000);
        hold = lineTieNs;
        pulse(3'h2);
        chk(refTieNs, 0);
        chk(lineTieNs, hold);
        hold = refTieNs;
        pulse(3'h1);
        chk(lineTieNs, 0);
        chk(mtieNs, 0);
        chk(availCount, 0);
        chk(refTieNs, hold);
        cyc(20400);
        @(negedge ref_clk);
        chk(availCount, 7'h64);
        @(posedge ref_clk) drainOn <= 1'b1;
        pops = 0;
        for (int i = 0; i < 600 && availCount !== 0; i++) begin
            @(negedge ref_clk);
            if (waveOutValid === 1'b1 && waveOutReady === 1'b1) begin
                pops++;
                chk(waveOutData, 0);
            end
        end
        @(negedge ref_clk);
        chk(availCount, 0);
        chkRange(pops, 100, 101);
        results();
    end
endmodule
